// ==== core/flash_bus_defs.svh ====
// timing figures, field positions and command values for the flash bus controller
// assumes the controller clock runs at the rate given by FBC_CLK_NS
`ifndef FLASH_BUS_DEFS_SVH
`define FLASH_BUS_DEFS_SVH

`define FBC_CLK_NS 5
// timing figures in ns; plain defaults, set them to the part in use
`define FBC_ACCESS_NS 100
`define FBC_WE_PULSE_NS 50
`define FBC_WR_RECOVER_NS 20
`define FBC_RESET_PULSE_NS 500
`define FBC_READY_ACCESS_NS 20
`define FBC_RESET_HIGH_NS 50
// least time in ns to whole cycles, rounded up
`define FBC_CYC(ns) (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`define FBC_BYPASS_PROG_CMD 8'ha0
`define FBC_A6_BIT 6
`define FBC_A1_BIT 1
`define FBC_A0_BIT 0
`define FBC_WORD_OE 16'hffff
`define FBC_BYTE_WR_OE 16'h80ff
`define FBC_BYTE_RD_OE 16'h8000
`define FBC_DQ_ADDR_BIT 15

`endif

// ==== core/flash_bus_pkg.sv ====
// types shared by the flash bus controller and its users
// assumes flash_bus_defs.svh supplies the numeric constants
package flash_bus_pkg;
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_ACCEL_PROG, OP_PROTECT, OP_UNPROTECT, OP_RESET
   } op_e;

   typedef struct packed {
      op_e op;
      logic [20:0] addr;
      logic [15:0] wdata;
      logic [4:0] group;
   } req_s;

   typedef struct packed {
      logic [15:0] rdata;
      logic refused;
      logic reissue;
   } rsp_s;

   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic resetN;
      logic resetHv;
      logic accelHv;
      logic wpLowN;
      logic byteN;
      logic [19:0] addr;
      logic [15:0] dqOut;
      logic [15:0] dqOe;
   } pins_s;
endpackage : flash_bus_pkg

// ==== core/flash_bus_mode_control.sv ====
// host-side bus controller driving a dual-bank asynchronous flash through its pins
// assumes dqIn and readyBusyN are synchronous to clk_sys; the board makes the high voltages
`timescale 1ns/1ps
`include "flash_bus_defs.svh"

module flash_bus_mode_control #(
   parameter int GROUPS = 17
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic reqValid,
   output logic reqReady,
   input wire flash_bus_pkg::req_s req,
   output logic rspValid,
   output flash_bus_pkg::rsp_s rsp,
   input wire logic byteWide,
   input wire logic writeProtect,
   output flash_bus_pkg::pins_s pins,
   input wire logic [15:0] dqIn,
   input wire logic readyBusyN
);
   localparam int ACC_CYC = `FBC_CYC(`FBC_ACCESS_NS);
   localparam int WE_CYC = `FBC_CYC(`FBC_WE_PULSE_NS);
   localparam int WR_CYC = `FBC_CYC(`FBC_WR_RECOVER_NS);
   localparam int RP_CYC = `FBC_CYC(`FBC_RESET_PULSE_NS);
   localparam int RB_CYC = `FBC_CYC(`FBC_READY_ACCESS_NS);
   localparam int RH_CYC = `FBC_CYC(`FBC_RESET_HIGH_NS);

   typedef enum logic [2:0] {
      IDLE, WR_SETUP, WR_STROBE, WR_HOLD, RD_WAIT, RST_PULSE, RST_BUSY, RST_RECOV
   } state_e;

   state_e state_r, state_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   flash_bus_pkg::req_s cur_r, cur_nxt;
   flash_bus_pkg::pins_s pins_r, pins_nxt;
   flash_bus_pkg::rsp_s rsp_r, rsp_nxt;
   logic rspValid_r, rspValid_nxt;
   logic [GROUPS-1:0] mask_r, mask_nxt;
   logic busyAtReset_r, busyAtReset_nxt;

   assign reqReady = (state_r == IDLE);
   assign pins = pins_r;
   assign rsp = rsp_r;
   assign rspValid = rspValid_r;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      phase_nxt = phase_r;
      cur_nxt = cur_r;
      pins_nxt = pins_r;
      rsp_nxt = rsp_r;
      rspValid_nxt = 1'b0;
      mask_nxt = mask_r;
      busyAtReset_nxt = busyAtReset_r;
      pins_nxt.byteN = byteWide;
      pins_nxt.wpLowN = ~writeProtect;
      unique case (state_r)
         IDLE: begin
            pins_nxt.ceN = 1'b1;
            pins_nxt.oeN = 1'b1;
            pins_nxt.weN = 1'b1;
            pins_nxt.dqOe = 16'h0000;
            if (reqValid) begin
               cur_nxt = req;
               phase_nxt = 1'b0;
               rsp_nxt = '0;
               // address pins: word address, or byte address with its lsb on dq15
               pins_nxt.addr = byteWide ? req.addr[19:0] : req.addr[20:1];
               unique case (req.op)
                  flash_bus_pkg::OP_READ: begin
                     pins_nxt.ceN = 1'b0;
                     pins_nxt.oeN = 1'b0;
                     pins_nxt.dqOut = {req.addr[0], 15'h0000};
                     pins_nxt.dqOe = byteWide ? 16'h0000 : `FBC_BYTE_RD_OE;
                     cnt_nxt = 16'(ACC_CYC);
                     state_nxt = RD_WAIT;
                  end
                  flash_bus_pkg::OP_RESET: begin
                     busyAtReset_nxt = ~readyBusyN;
                     pins_nxt.resetN = 1'b0;
                     cnt_nxt = 16'(RP_CYC);
                     state_nxt = RST_PULSE;
                  end
                  flash_bus_pkg::OP_UNPROTECT: begin
                     // unprotecting with any group left open is refused outright
                     if (!(&mask_r)) begin
                        rsp_nxt.refused = 1'b1;
                        rspValid_nxt = 1'b1;
                     end else begin
                        pins_nxt.resetHv = 1'b1;
                        pins_nxt.addr[`FBC_A6_BIT] = 1'b1;
                        pins_nxt.addr[`FBC_A1_BIT] = 1'b1;
                        pins_nxt.addr[`FBC_A0_BIT] = 1'b0;
                        state_nxt = WR_SETUP;
                     end
                  end
                  default: begin
                     pins_nxt.ceN = 1'b0;
                     pins_nxt.dqOut = byteWide ? req.wdata : {req.addr[0], 7'h00, req.wdata[7:0]};
                     pins_nxt.dqOe = byteWide ? `FBC_WORD_OE : `FBC_BYTE_WR_OE;
                     if (req.op == flash_bus_pkg::OP_ACCEL_PROG) begin
                        // bypass program: command cycle first, then the data cycle
                        pins_nxt.accelHv = 1'b1;
                        pins_nxt.dqOut[7:0] = `FBC_BYPASS_PROG_CMD;
                        pins_nxt.dqOut[14:8] = 7'h00;
                     end
                     if (req.op == flash_bus_pkg::OP_PROTECT) begin
                        pins_nxt.resetHv = 1'b1;
                        pins_nxt.addr[`FBC_A6_BIT] = 1'b0;
                        pins_nxt.addr[`FBC_A1_BIT] = 1'b1;
                        pins_nxt.addr[`FBC_A0_BIT] = 1'b0;
                     end
                     state_nxt = WR_SETUP;
                  end
               endcase
            end
         end
         WR_SETUP: begin
            // output enable stays high for the whole strobe
            pins_nxt.ceN = 1'b0;
            pins_nxt.oeN = 1'b1;
            pins_nxt.weN = 1'b0;
            pins_nxt.dqOe = pins_r.byteN ? `FBC_WORD_OE : `FBC_BYTE_WR_OE;
            cnt_nxt = 16'(WE_CYC);
            state_nxt = WR_STROBE;
         end
         WR_STROBE: begin
            if (cnt_r > 16'h0001) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else begin
               // strobe rises before select so data is held across the latch edge
               pins_nxt.weN = 1'b1;
               cnt_nxt = 16'(WR_CYC);
               state_nxt = WR_HOLD;
            end
         end
         WR_HOLD: begin
            if (cnt_r > 16'h0001) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else if (cur_r.op == flash_bus_pkg::OP_ACCEL_PROG && !phase_r) begin
               phase_nxt = 1'b1;
               pins_nxt.addr = pins_r.byteN ? cur_r.addr[19:0] : cur_r.addr[20:1];
               pins_nxt.dqOut = pins_r.byteN ? cur_r.wdata
                                             : {cur_r.addr[0], 7'h00, cur_r.wdata[7:0]};
               state_nxt = WR_SETUP;
            end else begin
               pins_nxt.ceN = 1'b1;
               pins_nxt.dqOe = 16'h0000;
               pins_nxt.accelHv = 1'b0;
               pins_nxt.resetHv = 1'b0;
               if (cur_r.op == flash_bus_pkg::OP_PROTECT && cur_r.group < 5'(GROUPS)) begin
                  mask_nxt[cur_r.group] = 1'b1;
               end
               if (cur_r.op == flash_bus_pkg::OP_UNPROTECT) begin
                  mask_nxt = '0;
               end
               rspValid_nxt = 1'b1;
               state_nxt = IDLE;
            end
         end
         RD_WAIT: begin
            // sample only once the select access time has run out
            if (cnt_r > 16'h0001) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else begin
               rsp_nxt.rdata = pins_r.byteN ? dqIn : {8'h00, dqIn[7:0]};
               rspValid_nxt = 1'b1;
               pins_nxt.ceN = 1'b1;
               pins_nxt.oeN = 1'b1;
               pins_nxt.dqOe = 16'h0000;
               state_nxt = IDLE;
            end
         end
         RST_PULSE: begin
            if (cnt_r > 16'h0001) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else begin
               pins_nxt.resetN = 1'b1;
               cnt_nxt = busyAtReset_r ? 16'(RB_CYC) : 16'(RH_CYC);
               state_nxt = busyAtReset_r ? RST_BUSY : RST_RECOV;
            end
         end
         RST_BUSY: begin
            // no timeout: the device alone decides when its reset is done
            if (readyBusyN) begin
               state_nxt = RST_RECOV;
            end
         end
         RST_RECOV: begin
            if (cnt_r > 16'h0001) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else begin
               rsp_nxt.reissue = busyAtReset_r;
               rspValid_nxt = 1'b1;
               state_nxt = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_r <= IDLE;
         cnt_r <= 16'h0000;
         phase_r <= 1'b0;
         cur_r <= '0;
         pins_r <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1, resetHv: 1'b0,
                     accelHv: 1'b0, wpLowN: 1'b1, byteN: 1'b1, addr: 20'h00000,
                     dqOut: 16'h0000, dqOe: 16'h0000};
         rsp_r <= '0;
         rspValid_r <= 1'b0;
         mask_r <= '0;
         busyAtReset_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
         cur_r <= cur_nxt;
         pins_r <= pins_nxt;
         rsp_r <= rsp_nxt;
         rspValid_r <= rspValid_nxt;
         mask_r <= mask_nxt;
         busyAtReset_r <= busyAtReset_nxt;
      end
   end

   // helper counters watched only by the checks below
   logic [15:0] ceLowCnt, resetLowCnt, sinceRelease, rbHighCnt;
   logic [1:0] accelStrobes;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ceLowCnt <= 16'h0000;
         resetLowCnt <= 16'h0000;
         sinceRelease <= 16'h0000;
         rbHighCnt <= 16'h0000;
         accelStrobes <= 2'b00;
      end else begin
         ceLowCnt <= (pins_r.ceN || pins_r.oeN) ? 16'h0000 : ceLowCnt + 16'h0001;
         resetLowCnt <= pins_r.resetN ? 16'h0000 : resetLowCnt + 16'h0001;
         sinceRelease <= !pins_r.resetN ? 16'h0000 : sinceRelease + 16'h0001;
         rbHighCnt <= (!pins_r.resetN || !readyBusyN) ? 16'h0000 : rbHighCnt + 16'h0001;
         if (!pins_r.accelHv) begin
            accelStrobes <= 2'b00;
         end else if (state_r == WR_SETUP) begin
            accelStrobes <= accelStrobes + 2'b01;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_write_oe_high: assert property (!pins.weN |-> pins.oeN && !pins.ceN)
      else $error("write strobe low without select low and output enable high");
   a_byte_upper_float: assert property (!pins.byteN |-> pins.dqOe[14:8] == 7'h00)
      else $error("upper data lines driven in byte mode");
   a_accel_two_cycle: assert property ($fell(pins.accelHv) |-> $past(accelStrobes) == 2'b10)
      else $error("accelerated program did not use two write cycles");
   // the counter lags the pin by one cycle, so the sample edge adds one
   a_read_access_wait: assert property (state_r == RD_WAIT && state_nxt == IDLE
                                         |-> ceLowCnt + 16'h0001 >= 16'(ACC_CYC))
      else $error("read sampled before access time");
   a_reset_width: assert property ($rose(pins.resetN) |-> resetLowCnt >= 16'(RP_CYC))
      else $error("reset pulse too short");
   a_idle_recovery: assert property (state_r == RST_RECOV && state_nxt == IDLE && !busyAtReset_r
                                      |-> sinceRelease + 16'h0001 >= 16'(RH_CYC))
      else $error("access before reset-high recovery");
   a_busy_recovery: assert property (state_r == RST_RECOV && state_nxt == IDLE && busyAtReset_r
                                      |-> rbHighCnt >= 16'(RB_CYC))
      else $error("access before ready recovery");
   a_reset_no_access: assert property (state_r inside {RST_PULSE, RST_BUSY, RST_RECOV}
                                        |-> pins.ceN && pins.weN)
      else $error("bus access during reset recovery");
   a_reissue_flag: assert property (state_r == RST_RECOV && state_nxt == IDLE
                                     |=> rspValid && rsp.reissue == $past(busyAtReset_r))
      else $error("reissue flag wrong after reset");
   a_unprotect_guard: assert property (pins.resetHv && !pins.weN && pins.addr[`FBC_A6_BIT]
                                        |-> &mask_r)
      else $error("unprotect write with a group still open");

   c_read: cover property (state_r == RD_WAIT ##1 rspValid);
   c_accel: cover property ($fell(pins.accelHv));
   c_busy_reset: cover property (state_r == RST_BUSY ##1 state_r == RST_RECOV);
   c_unprotect: cover property (pins.resetHv && !pins.weN && pins.addr[`FBC_A6_BIT]);
endmodule : flash_bus_mode_control

// ==== bench/flash_dev_model.sv ====
// behavioural flash device answering the controller's pins
// assumes pins change just after clk_sys edges; only bypass program and high-voltage group protect and unprotect are decoded
`timescale 1ns/1ps

module flash_dev_model (
   input wire logic clk_sys,
   input wire flash_bus_pkg::pins_s pins,
   output logic [15:0] dqIn,
   output logic readyBusyN
);
   logic [15:0] mem [int];
   logic [255:0] prot = '0;
   logic [15:0] last = 16'h0000;
   logic [15:0] drive;
   logic [15:0] rd;
   logic [15:0] dLat = 16'h0000;
   logic [19:0] aLat = 20'h00000;
   logic selPrev = 1'b0;
   logic armed = 1'b0;
   int busy = 0;
   int kLat = 0;
   int rKey;

   // wire level: host lanes win, the rest is what the device drives
   assign dqIn = (pins.dqOut & pins.dqOe) | (drive & ~pins.dqOe);
   assign readyBusyN = (busy == 0);

   always_comb begin
      rKey = pins.byteN ? int'(pins.addr) : int'({1'b1, pins.addr, dqIn[15]});
      rd = mem.exists(rKey) ? mem[rKey] : 16'hffff;
      // released lines flip so a stale value never looks valid
      drive = ~last;
      if (!pins.ceN && !pins.oeN && pins.resetN) begin
         // data stays driven while the address holds, so sleep never shows on the pins
         if (pins.byteN) begin
            drive = rd;
         end else begin
            drive[7:0] = rd[7:0];
         end
      end
   end

   task store();
      logic [7:0] g;
      g = aLat[19:12];
      if (pins.resetHv && aLat[1] && !aLat[0]) begin
         if (aLat[6]) begin
            prot <= '0;
         end else begin
            prot[g] <= 1'b1;
         end
      end else if (pins.accelHv && !armed && dLat[7:0] == 8'ha0) begin
         armed <= 1'b1;
      end else if ((pins.wpLowN || g > 8'h01) && (!prot[g] || armed || pins.resetHv)) begin
         mem[kLat] = pins.byteN ? dLat : {8'hff, dLat[7:0]};
         busy <= 24;
         armed <= 1'b0;
      end
   endtask : store

   always @(posedge clk_sys) begin
      last <= dqIn;
      if (!pins.resetN) begin
         armed <= 1'b0;
         if (busy > 0) begin
            busy <= 3;
         end
      end else if (busy > 0) begin
         busy <= busy - 1;
      end
      selPrev <= !pins.ceN && !pins.weN;
      if (!pins.ceN && !pins.weN) begin
         dLat <= dqIn;
         if (!selPrev) begin
            aLat <= pins.addr;
            kLat <= rKey;
         end
      end else if (selPrev && pins.resetN) begin
         store();
      end
      if (!pins.accelHv) begin
         armed <= 1'b0;
      end
   end
endmodule : flash_dev_model

// ==== bench/testbench.sv ====
// self-checking bench: controller driving the behavioural flash model
// assumes default timing figures and GROUPS of 17 in the controller
`timescale 1ns/1ps
`include "flash_bus_defs.svh"

module testbench;
   localparam int ACC = `FBC_CYC(`FBC_ACCESS_NS);
   localparam int RP = `FBC_CYC(`FBC_RESET_PULSE_NS);
   localparam int RH = `FBC_CYC(`FBC_RESET_HIGH_NS);
   localparam int RB = `FBC_CYC(`FBC_READY_ACCESS_NS);
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic reqValid = 1'b0;
   logic reqReady;
   logic rspValid;
   logic readyBusyN;
   logic byteWide = 1'b1;
   logic writeProtect = 1'b0;
   flash_bus_pkg::req_s req = '0;
   flash_bus_pkg::rsp_s rsp;
   flash_bus_pkg::pins_s pins;
   logic [15:0] dqIn;
   int nFail = 0;
   int checked = 0;
   int lat = 0;
   int ceLow = 0;
   int rstLow = 0;

   always #2.5 clk_sys = ~clk_sys;

   flash_bus_mode_control flash_bus_mode_control_inst (.clk_sys(clk_sys), .resetn(resetn),
      .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp),
      .byteWide(byteWide), .writeProtect(writeProtect), .pins(pins), .dqIn(dqIn),
      .readyBusyN(readyBusyN));
   flash_dev_model flash_dev_model_inst (.clk_sys(clk_sys), .pins(pins), .dqIn(dqIn),
      .readyBusyN(readyBusyN));

   task automatic bad(input string msg);
      nFail++;
      $display("BAD %0t %s", $time, msg);
   endtask : bad

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checked++;
      if (got !== exp) bad($sformatf("%s got %h want %h", msg, got, exp));
   endtask : chk

   task automatic chk_min(input int got, input int least, input string msg);
      checked++;
      if (got < least) bad($sformatf("%s took %0d, less than %0d", msg, got, least));
   endtask : chk_min

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, nFail);
      if (nFail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // one request, counting clock cycles until the answer pulse
   task automatic do_op(input flash_bus_pkg::op_e kind, input logic [20:0] a,
                        input logic [15:0] d, input logic [4:0] g);
      int n;
      n = 0;
      lat = 0;
      ceLow = 0;
      rstLow = 0;
      reqValid <= 1'b1;
      req <= '{op: kind, addr: a, wdata: d, group: g};
      @(negedge clk_sys);
      while (reqReady !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
      reqValid <= 1'b0;
      while (rspValid !== 1'b1 && lat < 1000) begin
         @(negedge clk_sys);
         lat++;
         ceLow += int'(pins.ceN === 1'b0);
         rstLow += int'(pins.resetN === 1'b0);
      end
      if (rspValid !== 1'b1 || n >= 50) begin
         bad("no answer");
         end_sim();
      end
      @(posedge clk_sys);
   endtask : do_op

   task automatic wr(input logic [20:0] a, input logic [15:0] d);
      do_op(flash_bus_pkg::OP_WRITE, a, d, 5'h00);
   endtask : wr

   task automatic rd(input logic [20:0] a, input logic [15:0] exp, input logic [15:0] m);
      do_op(flash_bus_pkg::OP_READ, a, 16'h0000, 5'h00);
      chk(rsp.rdata & m, exp, "read data");
   endtask : rd

   // bus framing watched on every cycle
   always @(negedge clk_sys) begin
      if (resetn && !pins.weN) chk({14'h0, pins.ceN, pins.oeN}, 16'h0001, "write frame");
      // in byte mode dq15 carries the byte address, so the host keeps driving it
      if (resetn && !pins.oeN)
         chk(pins.dqOe & (pins.byteN ? 16'hffff : 16'h7fff), 16'h0000, "contention");
      if (resetn && !pins.byteN && !pins.weN) chk(pins.dqOe & 16'h7f00, 16'h0000, "lanes");
   end

   task automatic t_word();
      chk({12'h0, pins.ceN, pins.oeN, pins.weN, pins.resetN}, 16'h000f, "idle pins");
      wr(21'h00100, 16'h1234);
      rd(21'h00100, 16'h1234, 16'hffff);
      chk_min(ceLow, ACC, "select to data");
      $display("test word done");
   endtask : t_word

   task automatic t_byte();
      byteWide <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({15'h0, pins.byteN}, 16'h0000, "width pin");
      @(posedge clk_sys);
      wr(21'h00201, 16'h005a);
      wr(21'h00200, 16'h00a5);
      rd(21'h00201, 16'h005a, 16'h00ff);
      rd(21'h00200, 16'h00a5, 16'h00ff);
      byteWide <= 1'b1;
      @(posedge clk_sys);
      @(posedge clk_sys);
      $display("test byte done");
   endtask : t_byte

   task automatic t_wp();
      writeProtect <= 1'b1;
      wr(21'h00010, 16'hbeef);
      rd(21'h00010, 16'hffff, 16'hffff);
      writeProtect <= 1'b0;
      wr(21'h00010, 16'hbeef);
      rd(21'h00010, 16'hbeef, 16'hffff);
      $display("test protect pin done");
   endtask : t_wp

   task automatic t_groups();
      do_op(flash_bus_pkg::OP_PROTECT, 21'h05000, 16'h0000, 5'd5);
      wr(21'h05004, 16'h1111);
      rd(21'h05004, 16'hffff, 16'hffff);
      do_op(flash_bus_pkg::OP_UNPROTECT, 21'h00000, 16'h0000, 5'd0);
      chk({15'h0, rsp.refused}, 16'h0001, "early unprotect");
      do_op(flash_bus_pkg::OP_ACCEL_PROG, 21'h05004, 16'h2222, 5'd5);
      rd(21'h05004, 16'h2222, 16'hffff);
      for (int g = 0; g < 17; g++) begin
         do_op(flash_bus_pkg::OP_PROTECT, {g[8:0], 12'h000}, 16'h0000, g[4:0]);
      end
      do_op(flash_bus_pkg::OP_UNPROTECT, 21'h00000, 16'h0000, 5'd0);
      chk({15'h0, rsp.refused}, 16'h0000, "full unprotect");
      wr(21'h05008, 16'h3333);
      rd(21'h05008, 16'h3333, 16'hffff);
      $display("test groups done");
   endtask : t_groups

   task automatic t_reset();
      int n;
      n = 0;
      while (readyBusyN !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk({15'h0, readyBusyN}, 16'h0001, "device idle");
      do_op(flash_bus_pkg::OP_RESET, 21'h00000, 16'h0000, 5'd0);
      chk({15'h0, rsp.reissue}, 16'h0000, "idle reset flag");
      chk_min(rstLow, RP, "reset pulse");
      chk_min(lat - rstLow, RH, "idle recovery");
      rd(21'h00100, 16'h1234, 16'hffff);
      wr(21'h00300, 16'h4444);
      do_op(flash_bus_pkg::OP_RESET, 21'h00000, 16'h0000, 5'd0);
      chk({15'h0, rsp.reissue}, 16'h0001, "busy reset flag");
      chk_min(lat - rstLow, RB + 3, "busy recovery");
      wr(21'h00300, 16'h4444);
      rd(21'h00300, 16'h4444, 16'hffff);
      $display("test reset done");
   endtask : t_reset

   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_word();
      t_byte();
      t_wp();
      t_groups();
      t_reset();
      end_sim();
   end
endmodule : testbench
